/* File: logic/cmpdac_ctrl.sv */
// Comparator and reference DAC control, status and Avalon-MM register slave
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module cmpdac_ctrl (
   input  wire  logic                           sys_clk,
   input  wire  logic                           rst_n,
   input  wire  logic [cmpdac_pkg::ADDR_W-1:0]  avs_address,
   input  wire  logic                           avs_read,
   input  wire  logic                           avs_write,
   input  wire  logic [cmpdac_pkg::DATA_W-1:0]  avs_writedata,
   input  wire  logic [3:0]                     avs_byteenable,
   output logic       [cmpdac_pkg::DATA_W-1:0]  avs_readdata,
   output logic                                 avs_waitrequest,
   input  wire  logic                           raw_compare_output,
   input  wire  logic                           stop_mode,
   output cmpdac_pkg::cmpdac_analog_t           analog_cfg,
   output logic                                 result_pad_out,
   output logic                                 result_pad_func,
   output logic                                 cpu_irq,
   output logic                                 stop_wakeup
);
   import cmpdac_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   cmpdac_analog_t     cfg_r;
   logic               irq_en_r;
   logic               pin_out_en_r;
   logic [1:0]         mode_r;
   logic               flag_r;
   logic               flag_nxt;
   logic               sync1_r;
   logic               sync2_r;
   logic               sync3_r;
   logic               result_r;
   logic               rise;
   logic               fall;
   logic               edge_ok;
   logic               wait_r;
   logic [DATA_W-1:0]  rdata_r;
   logic [REG_W-1:0]   rd_val;
   logic [2:0]         idx;
   logic               take;
   logic               wr_lo;
   logic [REG_W-1:0]   wd;
   logic               irq_r;
   logic               pad_out_r;
   logic               pad_func_r;
   logic               wake_r;
   logic               wake_arm_r;

   assign idx   = avs_address[ADDR_W-1:2];
   assign wd    = avs_writedata[REG_W-1:0];
   // Transfer completes at the edge where waitrequest is seen low
   assign take  = (avs_read | avs_write) & ~wait_r;
   assign wr_lo = take & avs_write & avs_byteenable[0];

   // ****************************************
   // Bus handshake
   // ****************************************

   // Waitrequest drops for one cycle per request
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 1'b1;
      end else if (take) begin
         wait_r <= 1'b1;
      end else if (avs_read | avs_write) begin
         wait_r <= 1'b0;
      end
   end

   // Read mux; reserved and unmapped bits read as zero
   always_comb begin
      rd_val = REG_RST;
      if (idx == IDX_STATUS) begin
         rd_val[ST_ENABLE]              = cfg_r.comparator_enable;
         rd_val[ST_HYST]                = cfg_r.hysteresis_high;
         rd_val[ST_FLAG]                = flag_r;
         rd_val[ST_IRQ_EN]              = irq_en_r;
         rd_val[ST_RESULT]              = result_r;
         rd_val[ST_PIN_EN]              = pin_out_en_r;
         rd_val[ST_MODE_LO +: 2]        = mode_r;
      end else if (idx == IDX_INSEL) begin
         rd_val[SEL_POS_LO +: SEL_W]    = cfg_r.positive_input_select; // [RQ1]
         rd_val[SEL_NEG_LO +: SEL_W]    = cfg_r.negative_input_select;
      end else if (idx == IDX_DACCTL) begin
         rd_val[DAC_EN]                 = cfg_r.ref_converter_enable;
         rd_val[DAC_SRC]                = cfg_r.ref_converter_source;
         rd_val[DAC_CODE_LO +: CODE_W]  = cfg_r.ref_converter_code;
      end else if (idx == IDX_PINEN) begin
         rd_val[PIN_EN_LO +: PINS_W]    = cfg_r.analog_pin_enable; // [RQ7]
      end
   end

   // Read data captured while waitrequest is being released
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= '0;
      end else if (wait_r & avs_read) begin
         rdata_r <= {{(DATA_W-REG_W){1'b0}}, rd_val};
      end
   end

   // ****************************************
   // Configuration registers
   // ****************************************

   // Analog configuration; reset leaves comparator and DAC off
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= ANALOG_RST; // [RQ16]
      end else if (wr_lo) begin
         if (idx == IDX_STATUS) begin
            cfg_r.comparator_enable <= wd[ST_ENABLE];
            cfg_r.hysteresis_high   <= wd[ST_HYST];
         end else if (idx == IDX_INSEL) begin
            cfg_r.positive_input_select <= wd[SEL_POS_LO +: SEL_W]; // [RQ2] [RQ1]
            cfg_r.negative_input_select <= wd[SEL_NEG_LO +: SEL_W]; // [RQ3]
         end else if (idx == IDX_DACCTL) begin
            cfg_r.ref_converter_enable <= wd[DAC_EN];  // [RQ4]
            cfg_r.ref_converter_source <= wd[DAC_SRC]; // [RQ5]
            cfg_r.ref_converter_code   <= wd[DAC_CODE_LO +: CODE_W]; // [RQ6]
         end else if (idx == IDX_PINEN) begin
            cfg_r.analog_pin_enable <= wd[PIN_EN_LO +: PINS_W]; // [RQ8] [RQ7]
         end
      end
   end

   // Interrupt enable, pin enable and edge mode
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_r     <= 1'b0;
         pin_out_en_r <= 1'b0;
         mode_r       <= MODE_FALL_A;
      end else if (wr_lo && idx == IDX_STATUS) begin
         irq_en_r     <= wd[ST_IRQ_EN];
         pin_out_en_r <= wd[ST_PIN_EN];
         mode_r       <= wd[ST_MODE_LO +: 2];
      end
   end

   // ****************************************
   // Result synchroniser and edge detection
   // ****************************************

   // Two-stage synchroniser plus one history stage; frozen when clock stops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end else begin
         sync1_r <= raw_compare_output; // [RQ25] [RQ13]
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Readable result follows comparator, zero while disabled
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_r <= 1'b0;
      end else begin
         result_r <= cfg_r.comparator_enable & sync2_r; // [RQ12] [RQ23]
      end
   end

   assign rise = sync2_r & ~sync3_r; // [RQ25]
   assign fall = ~sync2_r & sync3_r;

   // Edge qualification by mode, only while enabled
   always_comb begin
      edge_ok = 1'b0;
      case (mode_r)
         MODE_FALL_A: edge_ok = fall; // [RQ11]
         MODE_RISE:   edge_ok = rise;
         MODE_FALL_B: edge_ok = fall;
         MODE_BOTH:   edge_ok = rise | fall;
         default:     edge_ok = 1'b0;
      endcase
      edge_ok = edge_ok & cfg_r.comparator_enable; // [RQ26]
   end

   // Sticky flag; a set in the clearing cycle wins
   always_comb begin
      flag_nxt = flag_r;
      if (wr_lo && idx == IDX_STATUS && !wd[ST_FLAG]) begin
         flag_nxt = 1'b0; // [RQ22]
      end
      if (edge_ok) begin
         flag_nxt = 1'b1; // [RQ10] [RQ14]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************

   // CPU interrupt gated by enable bit
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= flag_nxt & irq_en_r; // [RQ10] [RQ24]
      end
   end

   // Comparator pad path, only with pin enable
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_out_r  <= 1'b0;
         pad_func_r <= 1'b0;
      end else begin
         pad_func_r <= pin_out_en_r; // [RQ17]
         pad_out_r  <= pin_out_en_r & cfg_r.comparator_enable & sync2_r;
      end
   end

   // Stop wakeup: armed at last clock, fires on raw edge with no clock
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_arm_r <= 1'b0;
      end else begin
         wake_arm_r <= stop_mode & cfg_r.comparator_enable;
      end
   end

   // Asynchronous wake decode, combinational compare of raw output against sync2_r
   always_comb begin
      wake_r = 1'b0;
      if (wake_arm_r) begin
         case (mode_r)
            MODE_RISE: wake_r = raw_compare_output & ~sync2_r; // [RQ15]
            MODE_BOTH: wake_r = raw_compare_output ^ sync2_r;
            default:   wake_r = ~raw_compare_output & sync2_r;
         endcase
      end
   end

   assign avs_readdata    = rdata_r;
   assign avs_waitrequest = wait_r;
   assign analog_cfg      = cfg_r; // [RQ18]
   assign result_pad_out  = pad_out_r;
   assign result_pad_func = pad_func_r;
   assign cpu_irq         = irq_r;
   assign stop_wakeup     = wake_r;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   result_off_a: assert property (!cfg_r.comparator_enable |=> !result_r) // [RQ23]
      else $error("result bit not zero while disabled");

   result_track_a: assert property ( // [RQ12]
      cfg_r.comparator_enable ##1 cfg_r.comparator_enable
      |=> result_r == $past(sync1_r, 2))
      else $error("result bit does not follow comparator");

   flag_rise_a: assert property ( // [RQ11]
      cfg_r.comparator_enable && mode_r == MODE_RISE && rise |=> flag_r)
      else $error("rising edge did not set flag");

   flag_fall_only_a: assert property ( // [RQ11]
      mode_r == MODE_FALL_B && rise && !fall && !flag_r && !wr_lo |=> !flag_r)
      else $error("rising edge set flag in falling mode");

   flag_hold_a: assert property ( // [RQ14]
      flag_r && !(wr_lo && idx == IDX_STATUS && !wd[ST_FLAG]) |=> flag_r)
      else $error("flag dropped without a zero write");

   flag_clear_a: assert property ( // [RQ22]
      flag_r && wr_lo && idx == IDX_STATUS && !wd[ST_FLAG] && !edge_ok |=> !flag_r)
      else $error("zero write did not clear flag");

   flag_disabled_a: assert property ( // [RQ26]
      !cfg_r.comparator_enable && !flag_r && !wr_lo |=> !flag_r)
      else $error("flag set while comparator disabled");

   irq_gate_a: assert property (!irq_en_r |=> !cpu_irq) // [RQ24]
      else $error("interrupt raised while disabled");

   irq_follow_a: assert property ( // [RQ10]
      irq_en_r && $stable(irq_en_r) && $rose(flag_r) |-> cpu_irq)
      else $error("interrupt missing after flag set");

   pad_gate_a: assert property (!pin_out_en_r |=> !result_pad_out && !result_pad_func) // [RQ17]
      else $error("result reached pad without pin enable");

   reserved_sel_a: assert property ( // [RQ1]
      wait_r && avs_read && idx == IDX_INSEL
      |=> rdata_r[SEL_POS_LO+SEL_W +: SEL_W] == '0 && rdata_r[SEL_NEG_LO+SEL_W +: SEL_W] == '0)
      else $error("reserved select bits read nonzero");

   edge_latency_a: assert property ( // [RQ25]
      (cfg_r.comparator_enable && mode_r == MODE_BOTH && $changed(sync1_r))
      ##1 (cfg_r.comparator_enable && mode_r == MODE_BOTH) |=> flag_r)
      else $error("flag not set two clocks after synchronised change");

   wait_pulse_a: assert property (take |=> wait_r)
      else $error("waitrequest held low past one transfer");

   // Register writes land in the analog configuration
   insel_pos_a: assert property ( // [RQ2]
      wr_lo && idx == IDX_INSEL
      |=> analog_cfg.positive_input_select == $past(avs_writedata[SEL_POS_LO +: SEL_W]))
      else $error("positive select not stored");

   insel_neg_a: assert property ( // [RQ3]
      wr_lo && idx == IDX_INSEL
      |=> analog_cfg.negative_input_select == $past(avs_writedata[SEL_NEG_LO +: SEL_W]))
      else $error("negative select not stored");

   dac_enable_a: assert property ( // [RQ4]
      wr_lo && idx == IDX_DACCTL
      |=> analog_cfg.ref_converter_enable == $past(avs_writedata[DAC_EN]))
      else $error("converter enable not stored");

   dac_source_a: assert property ( // [RQ5]
      wr_lo && idx == IDX_DACCTL
      |=> analog_cfg.ref_converter_source == $past(avs_writedata[DAC_SRC]))
      else $error("converter source not stored");

   dac_code_a: assert property ( // [RQ6]
      wr_lo && idx == IDX_DACCTL
      |=> analog_cfg.ref_converter_code == $past(avs_writedata[DAC_CODE_LO +: CODE_W]))
      else $error("converter code not stored");

   pin_enable_a: assert property ( // [RQ8]
      wr_lo && idx == IDX_PINEN
      |=> analog_cfg.analog_pin_enable == $past(avs_writedata[PIN_EN_LO +: PINS_W]))
      else $error("analog pin enable not stored");

   reserved_pin_a: assert property ( // [RQ7]
      wait_r && avs_read && idx == IDX_PINEN |=> rdata_r[REG_W-1:PINS_W] == '0)
      else $error("reserved pin enable bits read nonzero");

   readdata_hi_a: assert property (avs_readdata[DATA_W-1:REG_W] == '0) // [RQ1]
      else $error("upper read data bits nonzero");

   // Edge modes not covered above
   flag_both_a: assert property ( // [RQ11]
      cfg_r.comparator_enable && mode_r == MODE_BOTH && fall |=> flag_r)
      else $error("falling edge missed in both-edge mode");

   flag_fall_a: assert property ( // [RQ11]
      cfg_r.comparator_enable && mode_r == MODE_FALL_A && fall |=> flag_r)
      else $error("falling edge missed in falling mode");

   rise_no_fall_a: assert property ( // [RQ11]
      mode_r == MODE_RISE && fall && !flag_r && !wr_lo |=> !flag_r)
      else $error("falling edge set flag in rising mode");

   flag_one_write_a: assert property ( // [RQ22]
      flag_r && wr_lo && idx == IDX_STATUS && wd[ST_FLAG] |=> flag_r)
      else $error("writing one changed the flag");

   pad_follow_a: assert property ( // [RQ17]
      pin_out_en_r && cfg_r.comparator_enable |=> result_pad_out == $past(sync2_r))
      else $error("pad does not follow result");

   wait_one_a: assert property (wait_r && (avs_read || avs_write) |=> !wait_r)
      else $error("more than one wait cycle");

   wake_rise_a: assert property ( // [RQ15]
      wake_arm_r && mode_r == MODE_RISE && raw_compare_output && !sync2_r |-> stop_wakeup)
      else $error("stop wakeup missing on rising edge");

endmodule : cmpdac_ctrl

/* File: common/cmpdac_pkg.sv */
// Constants, field layout and carrier types for the comparator and DAC control block
// Behaviour
// [RQ1] Input-select bits 7:6, 3:2 read zero, ignore writes
// [RQ2] Bits 5:4 route positive input; 11 is DAC
// [RQ3] Negative-select field routes negative input, same coding
// [RQ4] DAC control bit 7 enables DAC output
// [RQ5] DAC control bit 6: bandgap or supply reference
// [RQ6] Six-bit code sets DAC level (ref/64)*(code+1)
// [RQ7] Pin-enable bits 7:3 read zero, ignore writes
// [RQ8] Three pin-enable bits open each external input
// [RQ9] Software sets pin enable for chosen external input
// [RQ10] Valid edge sets flag; interrupt when enabled
// [RQ11] Mode 00/10 falling, 01 rising, 11 both
// [RQ12] Comparator output synchronised, readable, tracks result
// [RQ13] No update without clock; refresh after wakeup
// [RQ14] Flag stays set until software writes zero
// [RQ15] Stop-mode valid edge gives asynchronous wakeup
// [RQ16] Reset disables comparator and DAC, defaults all
// [RQ17] Result drives pin only with pin enable
// [RQ18] DAC feeds both input muxes, exported too
// [RQ19] Software configures DAC before comparator enable
// [RQ20] Software selects inputs before enable, never after
// [RQ21] Software writes DAC code before DAC enable
// [RQ22] Writing zero clears flag, one leaves it
// [RQ23] Result bit held zero while comparator disabled
// [RQ24] Status bit 4 gates the CPU interrupt
// [RQ25] Two-stage synchroniser, edge from successive samples
// [RQ26] Edges ignored, flag kept while comparator disabled
package cmpdac_pkg;

   // ****************************************
   // Bus geometry
   // ****************************************
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int REG_W  = 8;

   // Register indices; byte address is four times the index
   localparam logic [2:0] IDX_STATUS  = 3'h0;
   localparam logic [2:0] IDX_INSEL   = 3'h1;
   localparam logic [2:0] IDX_DACCTL  = 3'h2;
   localparam logic [2:0] IDX_PINEN   = 3'h3;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int ST_ENABLE   = 7;
   localparam int ST_HYST     = 6;
   localparam int ST_FLAG     = 5;
   localparam int ST_IRQ_EN   = 4;
   localparam int ST_RESULT   = 3;
   localparam int ST_PIN_EN   = 2;
   localparam int ST_MODE_LO  = 0;
   localparam int SEL_POS_LO  = 4;
   localparam int SEL_NEG_LO  = 0;
   localparam int DAC_EN      = 7;
   localparam int DAC_SRC     = 6;
   localparam int DAC_CODE_LO = 0;
   localparam int PIN_EN_LO   = 0;

   localparam int SEL_W  = 2;
   localparam int CODE_W = 6;
   localparam int PINS_W = 3;

   // ****************************************
   // Codes and reset values
   // ****************************************
   localparam logic [1:0] MODE_FALL_A = 2'h0;
   localparam logic [1:0] MODE_RISE   = 2'h1;
   localparam logic [1:0] MODE_FALL_B = 2'h2;
   localparam logic [1:0] MODE_BOTH   = 2'h3;
   localparam logic [1:0] SEL_DAC     = 2'h3;
   localparam logic [7:0] REG_RST     = 8'h00;

   // Analog configuration carried to the comparator and DAC macro
   typedef struct packed {
      logic              comparator_enable;
      logic              hysteresis_high;
      logic [SEL_W-1:0]  positive_input_select;
      logic [SEL_W-1:0]  negative_input_select;
      logic              ref_converter_enable;
      logic              ref_converter_source;
      logic [CODE_W-1:0] ref_converter_code;
      logic [PINS_W-1:0] analog_pin_enable;
   } cmpdac_analog_t;

   localparam cmpdac_analog_t ANALOG_RST = '0;

endpackage : cmpdac_pkg

/* File: dv/tb.sv */
// Self-checking testbench for the comparator and DAC control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module tb;
   import cmpdac_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   typedef struct packed {
      logic [2:0] idx;
      logic [7:0] wd;
      logic [7:0] rd;
   } cmpdac_row_t;
   logic                 sys_clk;
   logic                 rst_n;
   logic [ADDR_W-1:0]    avs_address;
   logic                 avs_read;
   logic                 avs_write;
   logic [DATA_W-1:0]    avs_writedata;
   logic [3:0]           avs_byteenable;
   logic [DATA_W-1:0]    avs_readdata;
   logic                 avs_waitrequest;
   logic                 raw_compare_output;
   logic                 stop_mode;
   cmpdac_analog_t       analog_cfg;
   cmpdac_analog_t       exp_cfg;
   logic                 result_pad_out;
   logic                 result_pad_func;
   logic                 cpu_irq;
   logic                 stop_wakeup;
   logic [7:0]           rdat;
   logic                 timed_out;
   int                   err_total = 0;
   int                   comparisons = 0;
   cmpdac_row_t          rows [8];

   // ****************************************
   // Design, watchdog and clock
   // ****************************************
   cmpdac_ctrl u_dut (
      .sys_clk            (sys_clk),
      .rst_n              (rst_n),
      .avs_address        (avs_address),
      .avs_read           (avs_read),
      .avs_write          (avs_write),
      .avs_writedata      (avs_writedata),
      .avs_byteenable     (avs_byteenable),
      .avs_readdata       (avs_readdata),
      .avs_waitrequest    (avs_waitrequest),
      .raw_compare_output (raw_compare_output),
      .stop_mode          (stop_mode),
      .analog_cfg         (analog_cfg),
      .result_pad_out     (result_pad_out),
      .result_pad_func    (result_pad_func),
      .cpu_irq            (cpu_irq),
      .stop_wakeup        (stop_wakeup)
   );

   cmpdac_tb_watch #(.LIMIT (5000)) u_watch (.sys_clk (sys_clk), .timed_out (timed_out));

   // Clock, 50 ns period
   initial begin
      sys_clk = 1'b0;
      forever begin
         #25 sys_clk = ~sys_clk;
      end
   end

   // ****************************************
   // Tasks
   // ****************************************
   // Write: hold until waitrequest seen low, then let one edge pass
   task automatic bus_wr(input logic [2:0] i, input logic [7:0] d);
      avs_address   <= {i, 2'h0};
      avs_writedata <= {24'h000000, d};
      avs_write     <= 1'b1;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge sys_clk);
      end
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask : bus_wr

   // Read: data taken at the edge where waitrequest is seen low
   task automatic bus_rd(input logic [2:0] i, output logic [7:0] d);
      avs_address <= {i, 2'h0};
      avs_read    <= 1'b1;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge sys_clk);
      end
      d = avs_readdata[7:0];
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask : bus_rd

   task automatic end_test(input string nm);
      $display("Test %s done", nm);
   endtask : end_test

   task automatic print_verdict();
      if (timed_out === 1'b1) begin
         err_total++;
         $display("[FAIL] timeout expected 0 seen 1");
      end
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   // Watchdog path to the closing report
   initial begin
      wait (timed_out === 1'b1);
      print_verdict();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      rows[0] = '{IDX_INSEL,  8'hFF, 8'h33};
      rows[1] = '{IDX_INSEL,  8'h9E, 8'h12};
      rows[2] = '{IDX_DACCTL, 8'h3F, 8'h3F};
      rows[3] = '{IDX_DACCTL, 8'hBF, 8'hBF};
      rows[4] = '{IDX_DACCTL, 8'h40, 8'h40};
      rows[5] = '{IDX_PINEN,  8'hFF, 8'h07};
      rows[6] = '{IDX_PINEN,  8'h05, 8'h05};
      rows[7] = '{3'h5,       8'hFF, 8'h00};
      rst_n              <= 1'b0;
      avs_address        <= '0;
      avs_read           <= 1'b0;
      avs_write          <= 1'b0;
      avs_writedata      <= '0;
      avs_byteenable     <= 4'hF;
      raw_compare_output <= 1'b0;
      stop_mode          <= 1'b0;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      `CHK("cfg after reset", ANALOG_RST, analog_cfg)
      `CHK("waitrequest idle", 1'b1, avs_waitrequest)
      `CHK("irq after reset", 1'b0, cpu_irq)
      bus_rd(IDX_STATUS, rdat);
      `CHK("status after reset", 8'h00, rdat)
      end_test("reset");
      for (int k = 0; k < 8; k++) begin
         bus_wr(rows[k].idx, rows[k].wd);
         bus_rd(rows[k].idx, rdat);
         `CHK("row readback", rows[k].rd, rdat)
      end
      exp_cfg = ANALOG_RST;
      exp_cfg.positive_input_select = 2'h1;
      exp_cfg.negative_input_select = 2'h2;
      exp_cfg.ref_converter_source  = 1'b1;
      exp_cfg.analog_pin_enable     = 3'h5;
      `CHK("cfg after rows", exp_cfg, analog_cfg)
      end_test("rows");
      bus_wr(IDX_DACCTL, 8'h3F);
      bus_wr(IDX_DACCTL, 8'hBF);
      bus_wr(IDX_INSEL, 8'h30);
      bus_wr(IDX_PINEN, 8'h01);
      bus_wr(IDX_STATUS, 8'h95);
      raw_compare_output <= 1'b1;
      repeat (3) @(posedge sys_clk);
      `CHK("irq before latency", 1'b0, cpu_irq)
      @(posedge sys_clk);
      `CHK("irq on rising edge", 1'b1, cpu_irq)
      bus_rd(IDX_STATUS, rdat);
      `CHK("status flag set", 8'hBD, rdat)
      `CHK("pad out", 1'b1, result_pad_out)
      `CHK("pad function", 1'b1, result_pad_func)
      `CHK("no wakeup when running", 1'b0, stop_wakeup)
      bus_wr(IDX_STATUS, 8'hBD);
      bus_rd(IDX_STATUS, rdat);
      `CHK("write one keeps flag", 8'hBD, rdat)
      bus_wr(IDX_STATUS, 8'h95);
      `CHK("irq after clear", 1'b0, cpu_irq)
      bus_rd(IDX_STATUS, rdat);
      `CHK("flag cleared", 8'h9D, rdat)
      end_test("edge and clear");
      raw_compare_output <= 1'b0;
      repeat (4) @(posedge sys_clk);
      bus_rd(IDX_STATUS, rdat);
      `CHK("rise mode ignores fall", 8'h95, rdat)
      bus_wr(IDX_STATUS, 8'h97);
      raw_compare_output <= 1'b1;
      repeat (4) @(posedge sys_clk);
      bus_rd(IDX_STATUS, rdat);
      `CHK("both mode rise", 8'hBF, rdat)
      bus_wr(IDX_STATUS, 8'h94);
      raw_compare_output <= 1'b0;
      repeat (4) @(posedge sys_clk);
      bus_rd(IDX_STATUS, rdat);
      `CHK("mode 00 fall", 8'hB4, rdat)
      bus_wr(IDX_STATUS, 8'h96);
      raw_compare_output <= 1'b1;
      repeat (4) @(posedge sys_clk);
      bus_rd(IDX_STATUS, rdat);
      `CHK("mode 10 ignores rise", 8'h9E, rdat)
      end_test("modes");
      bus_wr(IDX_STATUS, 8'h13);
      raw_compare_output <= 1'b0;
      repeat (4) @(posedge sys_clk);
      bus_rd(IDX_STATUS, rdat);
      `CHK("disabled ignores edge", 8'h13, rdat)
      `CHK("pad out off", 1'b0, result_pad_out)
      `CHK("pad function off", 1'b0, result_pad_func)
      bus_wr(IDX_STATUS, 8'h81);
      raw_compare_output <= 1'b1;
      repeat (4) @(posedge sys_clk);
      `CHK("irq gated off", 1'b0, cpu_irq)
      bus_rd(IDX_STATUS, rdat);
      `CHK("flag without irq", 8'hA9, rdat)
      end_test("disable and gate");
      bus_wr(IDX_STATUS, 8'h95);
      raw_compare_output <= 1'b0;
      repeat (3) @(posedge sys_clk);
      stop_mode <= 1'b1;
      repeat (2) @(posedge sys_clk);
      raw_compare_output <= 1'b1;
      @(negedge sys_clk);
      `CHK("stop wakeup", 1'b1, stop_wakeup)
      @(posedge sys_clk);
      stop_mode <= 1'b0;
      repeat (3) @(posedge sys_clk);
      end_test("stop wakeup");
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      `CHK("cfg in reset", ANALOG_RST, analog_cfg)
      `CHK("waitrequest in reset", 1'b1, avs_waitrequest)
      `CHK("irq in reset", 1'b0, cpu_irq)
      rst_n <= 1'b1;
      @(posedge sys_clk);
      bus_rd(IDX_STATUS, rdat);
      `CHK("status after reset", 8'h00, rdat)
      end_test("mid reset");
      print_verdict();
   end
endmodule : tb

/* File: dv/tb_unused.sv */
// Cycle watchdog that flags a run which never reaches its verdict
`timescale 1ns/1ps
module cmpdac_tb_watch #(
   parameter int LIMIT = 5000
) (
   input  wire logic  sys_clk,
   output logic       timed_out
);
   int   cycles = 0;
   logic hit_r  = 1'b0;

   // Count clock cycles and raise the flag at the ceiling
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles >= LIMIT) begin
         hit_r <= 1'b1;
      end
   end

   assign timed_out = hit_r;
endmodule : cmpdac_tb_watch
